// ---- src/serial_port_zero_pkg.sv ----
package serial_port_zero_pkg;

  // Register byte addresses, low 16 bits of the AXI address
  localparam logic [15:0] CTRL_OFS   = 16'hFFB0;
  localparam logic [15:0] TBUF_OFS   = 16'hFFB4;
  localparam logic [15:0] RBUF_OFS   = 16'hFFB8;
  localparam logic [15:0] STAT_OFS   = 16'hFFBC;
  localparam logic [15:0] BAUD_OFS   = 16'hFFC0;

  // Control register fields
  localparam int B_RUN  = 15;
  localparam int B_LOOP = 14;
  localparam int B_BRS  = 13;
  localparam int B_ODD  = 12;
  localparam int B_RSV  = 11;
  localparam int B_OE   = 10;
  localparam int B_FE   = 9;
  localparam int B_PE   = 8;
  localparam int B_OEN  = 7;
  localparam int B_FEN  = 6;
  localparam int B_PEN  = 5;
  localparam int B_REN  = 4;
  localparam int B_STP  = 3;
  localparam int B_MODE = 0;

  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_RSV_MASK = 16'h0800;
  localparam logic [15:0] BAUD_RESET    = 16'h0000;

  // Status register fields
  localparam int S_TBE   = 0;
  localparam int S_TC    = 1;
  localparam int S_RXF   = 2;
  localparam int S_TFULL = 3;
  localparam int S_TBUSY = 4;

  // Operating mode codes
  localparam logic [2:0] MODE_SYNC = 3'h0;
  localparam logic [2:0] MODE_8N   = 3'h1;
  localparam logic [2:0] MODE_7P   = 3'h3;
  localparam logic [2:0] MODE_8P   = 3'h7;

  // Timing: 16 baud ticks per bit, sample in the middle
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [1:0] PRE_LAST_F1  = 2'h1;
  localparam logic [1:0] PRE_LAST_F23 = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } frame_state_t;

endpackage

// ---- src/serial_port_zero.sv ----
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
// Summary of operation
// - Odd-select bit 12 picks parity sense
// - Odd-select resets to zero, even parity
// - Even parity: bit makes ones count even
// - Bit 15 runs or stops baud generator
// - Bit 14 enables internal loop-back
// - Bit 13 selects baud factor 1 or 2/3
// - Overrun flag bit 10, gated by bit 7
// - Framing flag bit 9, gated by bit 6
// - Parity flag bit 8, gated by bit 5
// - Bit 4 enables receive; sync clears it
// - Bit 3 selects one or two stops
// - Bits 2..0 select operating mode
// - Control resets to zero; bit 11 reserved
// - Idle transmitter loads buffer immediately
// - Buffer-empty request set on each load
// - Full indicator: set on write, cleared on load
// - Complete request set before final stop bit; in sync mode before the last data bit
// - Frame end reloads full buffer, next frame
// - Refilled frames follow back to back
// - Buffer-empty request is separate source
module serial_port_zero (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line
  input  wire logic        rxd,
  output logic             txd,
  output logic             shift_clk,
  // Requests
  output logic             tx_buffer_empty_request,
  output logic             tx_complete_request,
  output logic             rx_request
);

  function automatic logic parity_of(input logic [7:0] data, input logic seven,
                                     input logic odd);
    logic p;
    p = ^data[6:0];
    if (!seven) begin
      p = p ^ data[7];
    end
    parity_of = p ^ odd;
  endfunction

  function automatic logic hits(input logic [31:0] addr, input logic [15:0] ofs);
    hits = (addr[15:2] == ofs[15:2]);
  endfunction

  logic [15:0]  ctrl_q;
  logic [15:0]  ctrl_d;
  logic [15:0]  baud_q;
  logic         aw_hold_q;
  logic         w_hold_q;
  logic [31:0]  awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         awready_q;
  logic         wready_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         arready_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;
  logic         do_wr;
  logic         rd_take;
  logic [31:0]  rd_data;
  logic         rd_ok;
  logic         wr_ctrl;
  logic         wr_tbuf;
  logic         wr_stat;
  logic         wr_baud;
  logic         rd_rbuf;
  logic [1:0]   pre_q;
  logic [15:0]  brg_q;
  logic         tick_q;
  logic [2:0]   mode;
  logic         is_sync;
  logic         has_par;
  logic         seven;
  logic [2:0]   last_bit;
  logic [7:0]   tbuf_q;
  logic         tbuf_full_q;
  logic         tx_load;
  logic         tx_end;
  serial_port_zero_pkg::frame_state_t tx_state_q;
  logic [3:0]   tx_tick_q;
  logic [2:0]   tx_bit_q;
  logic [7:0]   tx_shift_q;
  logic         tx_par_q;
  logic         tx_stop2_q;
  logic         tx_line_q;
  logic         tx_bit_end;
  logic         tc_set;
  logic         tbe_q;
  logic         tc_q;
  logic         txd_q;
  logic         sclk_q;
  logic         rxd_meta_q;
  logic         rxd_sync_q;
  logic         rx_in;
  serial_port_zero_pkg::frame_state_t rx_state_q;
  logic [3:0]   rx_tick_q;
  logic [2:0]   rx_bit_q;
  logic [7:0]   rx_shift_q;
  logic [7:0]   rx_next;
  logic         rx_pbit_q;
  logic [7:0]   rbuf_q;
  logic         rx_full_q;
  logic         rx_done;
  logic [7:0]   rx_word;
  logic         rx_fe_ev;
  logic         rx_pe_ev;
  logic         rx_oe_ev;

  assign mode     = ctrl_q[serial_port_zero_pkg::B_MODE +: 3];
  assign is_sync  = (mode == serial_port_zero_pkg::MODE_SYNC);
  assign has_par  = (mode == serial_port_zero_pkg::MODE_7P) ||
                    (mode == serial_port_zero_pkg::MODE_8P);
  assign seven    = (mode == serial_port_zero_pkg::MODE_7P);
  assign last_bit = seven ? 3'h6 : 3'h7;

  // AXI write: address and data taken in either order, one write in flight
  assign do_wr   = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_ctrl = do_wr && hits(awaddr_q, serial_port_zero_pkg::CTRL_OFS);
  assign wr_tbuf = do_wr && hits(awaddr_q, serial_port_zero_pkg::TBUF_OFS) && wstrb_q[0];
  assign wr_stat = do_wr && hits(awaddr_q, serial_port_zero_pkg::STAT_OFS) && wstrb_q[0];
  assign wr_baud = do_wr && hits(awaddr_q, serial_port_zero_pkg::BAUD_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 32'h00000000;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= serial_port_zero_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_ctrl || hits(awaddr_q, serial_port_zero_pkg::TBUF_OFS) ||
                      hits(awaddr_q, serial_port_zero_pkg::STAT_OFS) || wr_baud ||
                      hits(awaddr_q, serial_port_zero_pkg::RBUF_OFS)) ?
                     serial_port_zero_pkg::RESP_OKAY : serial_port_zero_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // AXI read: one cycle from address to data
  assign rd_take = s_axi_arvalid && arready_q;
  assign rd_rbuf = rd_take && hits(s_axi_araddr, serial_port_zero_pkg::RBUF_OFS);

  always_comb begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (hits(s_axi_araddr, serial_port_zero_pkg::CTRL_OFS)) begin
      rd_data[15:0] = ctrl_q;
    end else if (hits(s_axi_araddr, serial_port_zero_pkg::TBUF_OFS)) begin
      rd_data[7:0] = tbuf_q;
    end else if (hits(s_axi_araddr, serial_port_zero_pkg::RBUF_OFS)) begin
      rd_data[7:0] = rbuf_q;
    end else if (hits(s_axi_araddr, serial_port_zero_pkg::STAT_OFS)) begin
      rd_data[serial_port_zero_pkg::S_TBE]   = tbe_q;
      rd_data[serial_port_zero_pkg::S_TC]    = tc_q;
      rd_data[serial_port_zero_pkg::S_RXF]   = rx_full_q;
      rd_data[serial_port_zero_pkg::S_TFULL] = tbuf_full_q;
      rd_data[serial_port_zero_pkg::S_TBUSY] = (tx_state_q != serial_port_zero_pkg::ST_IDLE);
    end else if (hits(s_axi_araddr, serial_port_zero_pkg::BAUD_OFS)) begin
      rd_data[15:0] = baud_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= serial_port_zero_pkg::RESP_OKAY;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_ok ? serial_port_zero_pkg::RESP_OKAY : serial_port_zero_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Control register; hardware error sets win over a clearing write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      if (wstrb_q[0]) begin
        ctrl_d[7:0] = wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        ctrl_d[15:8] = wdata_q[15:8];
      end
    end
    if (rx_done && is_sync && !(wr_ctrl && wstrb_q[0])) begin
      ctrl_d[serial_port_zero_pkg::B_REN] = 1'b0;
    end
    if (rx_oe_ev) begin
      ctrl_d[serial_port_zero_pkg::B_OE] = 1'b1;
    end
    if (rx_fe_ev) begin
      ctrl_d[serial_port_zero_pkg::B_FE] = 1'b1;
    end
    if (rx_pe_ev) begin
      ctrl_d[serial_port_zero_pkg::B_PE] = 1'b1;
    end
    ctrl_d = ctrl_d & ~serial_port_zero_pkg::CTRL_RSV_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= serial_port_zero_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_q <= serial_port_zero_pkg::BAUD_RESET;
    end else if (wr_baud) begin
      if (wstrb_q[0]) begin
        baud_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        baud_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Baud generator: prescale by 2 or 3, then reload counter gives 16x tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q  <= 2'h0;
      brg_q  <= serial_port_zero_pkg::BAUD_RESET;
      tick_q <= 1'b0;
    end else if (!ctrl_q[serial_port_zero_pkg::B_RUN]) begin
      pre_q  <= 2'h0;
      brg_q  <= baud_q;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (pre_q == (ctrl_q[serial_port_zero_pkg::B_BRS] ? serial_port_zero_pkg::PRE_LAST_F23 :
                    serial_port_zero_pkg::PRE_LAST_F1)) begin
        pre_q <= 2'h0;
        if (brg_q == 16'h0000) begin
          brg_q  <= baud_q;
          tick_q <= 1'b1;
        end else begin
          brg_q <= brg_q - 16'h0001;
        end
      end else begin
        pre_q <= pre_q + 2'h1;
      end
    end
  end

  // Transmit: holding buffer feeds the shift register
  assign tx_bit_end = tick_q && (tx_tick_q == serial_port_zero_pkg::OVS_LAST);
  assign tx_end     = tx_bit_end && (((tx_state_q == serial_port_zero_pkg::ST_STOP) && !tx_stop2_q) ||
                      (is_sync && (tx_state_q == serial_port_zero_pkg::ST_DATA) &&
                       (tx_bit_q == last_bit)));
  assign tx_load    = tbuf_full_q && ((tx_state_q == serial_port_zero_pkg::ST_IDLE) ||
                                      tx_end);
  assign tc_set     = tx_bit_end && (
                      (tx_state_q == serial_port_zero_pkg::ST_STOP && tx_stop2_q) ||
                      (!is_sync && !ctrl_q[serial_port_zero_pkg::B_STP] && (
                        (tx_state_q == serial_port_zero_pkg::ST_PAR) ||
                        (tx_state_q == serial_port_zero_pkg::ST_DATA && !has_par &&
                         tx_bit_q == last_bit)))) ||
                      (tick_q && is_sync && tx_state_q == serial_port_zero_pkg::ST_DATA &&
                       tx_tick_q == serial_port_zero_pkg::OVS_LAST &&
                       tx_bit_q == last_bit - 3'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbuf_q      <= 8'h00;
      tbuf_full_q <= 1'b0;
    end else begin
      if (wr_tbuf) begin
        tbuf_q <= wdata_q[7:0];
      end
      tbuf_full_q <= wr_tbuf || (tbuf_full_q && !tx_load);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_q <= serial_port_zero_pkg::ST_IDLE;
      tx_tick_q  <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
      tx_line_q  <= 1'b1;
    end else if (tx_load) begin
      tx_state_q <= is_sync ? serial_port_zero_pkg::ST_DATA : serial_port_zero_pkg::ST_START;
      tx_tick_q  <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= tbuf_q;
      tx_par_q   <= parity_of(tbuf_q, seven, ctrl_q[serial_port_zero_pkg::B_ODD]);
      tx_line_q  <= is_sync ? tbuf_q[0] : 1'b0;
    end else if (tick_q && tx_state_q != serial_port_zero_pkg::ST_IDLE) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_bit_end) begin
        case (tx_state_q)
          serial_port_zero_pkg::ST_START: begin
            tx_state_q <= serial_port_zero_pkg::ST_DATA;
            tx_line_q  <= tx_shift_q[0];
          end
          serial_port_zero_pkg::ST_DATA: begin
            tx_bit_q   <= tx_bit_q + 3'h1;
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_line_q  <= tx_shift_q[1];
            if (tx_bit_q == last_bit) begin
              tx_stop2_q <= ctrl_q[serial_port_zero_pkg::B_STP];
              if (is_sync) begin
                tx_state_q <= serial_port_zero_pkg::ST_IDLE;
                tx_line_q  <= 1'b1;
              end else if (has_par) begin
                tx_state_q <= serial_port_zero_pkg::ST_PAR;
                tx_line_q  <= tx_par_q;
              end else begin
                tx_state_q <= serial_port_zero_pkg::ST_STOP;
                tx_line_q  <= 1'b1;
              end
            end
          end
          serial_port_zero_pkg::ST_PAR: begin
            tx_state_q <= serial_port_zero_pkg::ST_STOP;
            tx_line_q  <= 1'b1;
          end
          serial_port_zero_pkg::ST_STOP: begin
            tx_stop2_q <= 1'b0;
            if (!tx_stop2_q) begin
              tx_state_q <= serial_port_zero_pkg::ST_IDLE;
            end
          end
          default: begin
            tx_state_q <= serial_port_zero_pkg::ST_IDLE;
            tx_line_q  <= 1'b1;
          end
        endcase
      end
    end
  end

  // Requests: hardware set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbe_q <= 1'b0;
      tc_q  <= 1'b0;
    end else begin
      tbe_q <= tx_load || (tbe_q && !(wr_stat && wdata_q[serial_port_zero_pkg::S_TBE]));
      tc_q  <= tc_set || (tc_q && !(wr_stat && wdata_q[serial_port_zero_pkg::S_TC]));
    end
  end

  // Receive line: two-stage synchroniser, loop-back takes the internal line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
    end else begin
      rxd_meta_q <= rxd;
      rxd_sync_q <= rxd_meta_q;
    end
  end

  assign rx_in    = ctrl_q[serial_port_zero_pkg::B_LOOP] ? tx_line_q : rxd_sync_q;
  assign rx_next  = {rx_in, rx_shift_q[7:1]};
  assign rx_done  = tick_q && (rx_tick_q == serial_port_zero_pkg::OVS_LAST) && (
                    (rx_state_q == serial_port_zero_pkg::ST_STOP) ||
                    (is_sync && rx_state_q == serial_port_zero_pkg::ST_DATA &&
                     rx_bit_q == last_bit));
  assign rx_word  = is_sync ? rx_next : (seven ? {1'b0, rx_shift_q[7:1]} : rx_shift_q);
  assign rx_fe_ev = rx_done && !is_sync && !rx_in && ctrl_q[serial_port_zero_pkg::B_FEN];
  assign rx_pe_ev = rx_done && !is_sync && has_par && ctrl_q[serial_port_zero_pkg::B_PEN] &&
                    (rx_pbit_q != parity_of(rx_word, seven, ctrl_q[serial_port_zero_pkg::B_ODD]));
  assign rx_oe_ev = rx_done && rx_full_q && !rd_rbuf && ctrl_q[serial_port_zero_pkg::B_OEN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_q <= serial_port_zero_pkg::ST_IDLE;
      rx_tick_q  <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_pbit_q  <= 1'b0;
    end else if (rx_state_q == serial_port_zero_pkg::ST_IDLE) begin
      rx_tick_q <= 4'h0;
      rx_bit_q  <= 3'h0;
      if (ctrl_q[serial_port_zero_pkg::B_REN] && ctrl_q[serial_port_zero_pkg::B_RUN]) begin
        if (is_sync) begin
          rx_state_q <= serial_port_zero_pkg::ST_DATA;
        end else if (!rx_in) begin
          rx_state_q <= serial_port_zero_pkg::ST_START;
        end
      end
    end else if (tick_q) begin
      rx_tick_q <= rx_tick_q + 4'h1;
      case (rx_state_q)
        serial_port_zero_pkg::ST_START: begin
          if (rx_tick_q == serial_port_zero_pkg::OVS_MID) begin
            rx_tick_q  <= 4'h0;
            rx_state_q <= rx_in ? serial_port_zero_pkg::ST_IDLE : serial_port_zero_pkg::ST_DATA;
          end
        end
        serial_port_zero_pkg::ST_DATA: begin
          if (rx_tick_q == serial_port_zero_pkg::OVS_LAST) begin
            rx_shift_q <= rx_next;
            rx_bit_q   <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) begin
              rx_state_q <= is_sync ? serial_port_zero_pkg::ST_IDLE :
                            (has_par ? serial_port_zero_pkg::ST_PAR : serial_port_zero_pkg::ST_STOP);
            end
          end
        end
        serial_port_zero_pkg::ST_PAR: begin
          if (rx_tick_q == serial_port_zero_pkg::OVS_LAST) begin
            rx_pbit_q  <= rx_in;
            rx_state_q <= serial_port_zero_pkg::ST_STOP;
          end
        end
        serial_port_zero_pkg::ST_STOP: begin
          if (rx_tick_q == serial_port_zero_pkg::OVS_LAST) begin
            rx_state_q <= serial_port_zero_pkg::ST_IDLE;
          end
        end
        default: rx_state_q <= serial_port_zero_pkg::ST_IDLE;
      endcase
    end
  end

  // Receive buffer; a new byte wins over a clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rbuf_q    <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (rx_done) begin
        rbuf_q <= rx_word;
      end
      rx_full_q <= rx_done || (rx_full_q && !rd_rbuf &&
                   !(wr_stat && wdata_q[serial_port_zero_pkg::S_RXF]));
    end
  end

  // Pins; loop-back holds the transmit pin idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_q  <= 1'b1;
      sclk_q <= 1'b1;
    end else begin
      txd_q  <= ctrl_q[serial_port_zero_pkg::B_LOOP] ? 1'b1 : tx_line_q;
      sclk_q <= !(is_sync && (((tx_state_q == serial_port_zero_pkg::ST_DATA) && !tx_tick_q[3]) ||
                              ((rx_state_q == serial_port_zero_pkg::ST_DATA) && !rx_tick_q[3])));
    end
  end

  assign s_axi_awready           = awready_q;
  assign s_axi_wready            = wready_q;
  assign s_axi_bvalid            = bvalid_q;
  assign s_axi_bresp             = bresp_q;
  assign s_axi_arready           = arready_q;
  assign s_axi_rvalid            = rvalid_q;
  assign s_axi_rdata             = rdata_q;
  assign s_axi_rresp             = rresp_q;
  assign txd                     = txd_q;
  assign shift_clk               = sclk_q;
  assign tx_buffer_empty_request = tbe_q;
  assign tx_complete_request     = tc_q;
  assign rx_request              = rx_full_q;

endmodule

// ---- verif/serial_port_zero_monitor.sv ----
`timescale 1ns/10ps
module serial_port_zero_monitor (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Line and requests
  input wire logic        txd,
  input wire logic        tx_buffer_empty_request,
  input wire logic        tx_complete_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_after_take: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write answer");
  a_b_blocks_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during answer");
  a_r_after_take: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("late read answer");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[15:0] == 16'hFFC4 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read");
  a_tbe_sw_clear:
    assert property ($fell(tx_buffer_empty_request) |-> $rose(s_axi_bvalid))
    else $error("empty request lost");
  a_tc_sw_clear:
    assert property ($fell(tx_complete_request) |-> $rose(s_axi_bvalid))
    else $error("complete request lost");
  a_tc_at_stop:
    assert property ($rose(tx_complete_request) |-> ##[0:2] txd) else $error("tc not at stop");
  a_bit_time:
    assert property ($fell(txd) |=> !txd [*8]) else $error("short low bit");
endmodule
bind serial_port_zero serial_port_zero_monitor serial_port_zero_monitor_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .txd, .tx_buffer_empty_request, .tx_complete_request);

// ---- verif/serial_peer.sv ----
`timescale 1ns/10ps
module serial_peer (
  // Clock and line
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  int          nb = 10, n_rx = 0, t_start = 0, t_prev = 0;
  logic [11:0] got;
  initial rxd = 1'b1;
  // Samples mid-bit; assumes 32 clocks per bit, so reload must stay 0
  always begin
    @(negedge txd);
    t_prev = t_start;
    t_start = int'($time);
    got = '0;
    repeat (16) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      got[i] = txd;
      repeat (i < nb - 1 ? 32 : 0) @(posedge aclk);
    end
    n_rx++;
  end
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (32) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// ---- verif/async_serial_parity_dbl_tx_tb_top.sv ----
`timescale 1ns/10ps
module async_serial_parity_dbl_tx_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, rxd, txd, shift_clk, rx_request;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
  logic        s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, tx_buffer_empty_request, tx_complete_request;
  int          n_fail = 0, cmp_count = 0;
  always #2 aclk = ~aclk;
  serial_port_zero serial_port_zero_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .shift_clk,
    .tx_buffer_empty_request, .tx_complete_request, .rx_request);
  serial_peer serial_peer_i (.aclk, .txd, .rxd);
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    s_axi_awaddr <= {16'h0000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int k = 0; k < 99; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) return;
    end
    n_fail++;
    final_report();
  endtask
  task automatic rd(input logic [15:0] a);
    s_axi_araddr <= {16'h0000, a};
    s_axi_arvalid <= 1'b1;
    for (int k = 0; k < 99; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        return;
      end
    end
    n_fail++;
    final_report();
  endtask
  task automatic wait_rx(input int n);
    for (int k = 0; k < 1500; k++) begin
      @(posedge aclk);
      if (serial_peer_i.n_rx >= n) return;
    end
    n_fail++;
    final_report();
  endtask
  // One frame out, parity worked out here from the data
  task automatic tx1(input logic [2:0] m, input logic o, input logic [7:0] v);
    logic [11:0] e;
    e = m == 3'h1 ? {3'h1, v, 1'b0} : m == 3'h3 ? {3'h1, ^v[6:0] ^ o, v[6:0], 1'b0}
      : {2'h1, ^v ^ o, v, 1'b0};
    serial_peer_i.nb = m == 3'h7 ? 11 : 10;
    wr(16'hFFB0, {16'h0000, 1'b1, 2'b00, o, 9'h000, m});
    wr(16'hFFBC, 32'h7);
    wr(16'hFFB4, {24'h0, v});
    wait_rx(serial_peer_i.n_rx + 1);
    chk({20'h0, serial_peer_i.got}, {20'h0, e});
    chk({30'h0, tx_complete_request, tx_buffer_empty_request}, 32'h3);
  endtask
  task automatic t_regs;
    rd(16'hFFB0);
    chk(d, 32'h0);
    wr(16'hFFB0, 32'h18FF);
    rd(16'hFFB0);
    chk(d, 32'h10FF);
    rd(16'hFFC4);
    chk({30'h0, r}, 32'h2);
  endtask
  task automatic t_b2b;
    serial_peer_i.nb = 11;
    wr(16'hFFB0, 32'h8009);
    wr(16'hFFB4, 32'h55);
    // Let the first word reach the shift register before refilling
    repeat (20) @(posedge aclk);
    wr(16'hFFB4, 32'hC3);
    rd(16'hFFBC);
    chk({31'h0, d[3]}, 32'h1);
    wait_rx(serial_peer_i.n_rx + 2);
    chk({20'h0, serial_peer_i.got}, {20'h0, 3'h3, 8'hC3, 1'b0});
    chk(32'(serial_peer_i.t_start - serial_peer_i.t_prev), 32'h580);
  endtask
  task automatic t_rx;
    wr(16'hFFB0, 32'h80F7);
    serial_peer_i.send({1'b1, 1'b1, 8'h81, 1'b0});
    repeat (64) @(posedge aclk);
    serial_peer_i.send({1'b0, 1'b0, 8'h7E, 1'b0});
    rd(16'hFFB0);
    chk(d, 32'h87F7);
    rd(16'hFFB8);
    chk(d, 32'h7E);
    repeat (400) @(posedge aclk);
    wr(16'hFFB0, 32'h8000);
    rd(16'hFFB0);
    chk(d, 32'h8000);
  endtask
  task automatic t_sync;
    wr(16'hFFB0, 32'h10);
    repeat (300) @(posedge aclk);
    rd(16'hFFB0);
    chk(d, 32'h10);
    wr(16'hFFB0, 32'h8010);
    repeat (300) @(posedge aclk);
    rd(16'hFFB0);
    chk(d, 32'h8000);
    chk({30'h0, rx_request, shift_clk}, 32'h3);
    rd(16'hFFB8);
    chk(d, 32'hFF);
  endtask
  // Factor 2/3 makes a loop-back frame outlast 400 clocks
  task automatic t_loop;
    int n;
    n = serial_peer_i.n_rx;
    wr(16'hFFB0, 32'hE011);
    wr(16'hFFB4, 32'h5A);
    repeat (400) @(posedge aclk);
    chk({31'h0, rx_request}, 32'h0);
    repeat (200) @(posedge aclk);
    rd(16'hFFB8);
    chk(d, 32'h5A);
    chk(32'(serial_peer_i.n_rx - n), 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    tx1(3'h1, 1'b0, 8'hA5);
    tx1(3'h7, 1'b0, 8'h3C);
    tx1(3'h7, 1'b1, 8'h31);
    tx1(3'h3, 1'b1, 8'hD6);
    t_b2b();
    t_rx();
    t_sync();
    t_loop();
    final_report();
  end
endmodule
